// >>> logic/dac_ctrl_regs.vh
/*
 constants of the converter update and monitor controller: bus offsets, field positions,
 reset values and timing counts. assumes a 50 MHz system clock.
*/
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH

// ----------------------------------------------------------
// bus offsets
// ----------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_CTRL 8'h08
`define OFS_CLRCODE 8'h0C
`define OFS_DAC_SEL 8'h10
`define OFS_DAC_DATA 8'h14

// ----------------------------------------------------------
// command word fields
// ----------------------------------------------------------
`define CMD_W 20
`define CMD_SEL_HI 19
`define CMD_SEL_LO 18
`define CMD_ADDR_MSB 17
`define CMD_ADDR_LSB 12
`define CMD_MON_MSB 11
`define CMD_MON_LSB 6
`define SFR_NOP 6'h00
`define SFR_CLRCODE 6'h01
`define SFR_SOFT_CLR 6'h02
`define SFR_PDOWN 6'h08
`define SFR_PUP 6'h09
`define SFR_CTRL 6'h0C
`define SFR_MONITOR 6'h0A
`define SFR_SOFT_RST 6'h0F
`define SEL_SFR 2'h0
`define SEL_GAIN 2'h1
`define SEL_OFFSET 2'h2
`define SEL_INPUT 2'h3

// ----------------------------------------------------------
// control register and monitor
// ----------------------------------------------------------
`define CTRL_MON_EN 7
`define CTRL_PD_HIZ 11
`define CTRL_RESET 12'h800
`define MON_LAST_CH 6'h26
`define MON_HIZ 6'h3F
`define NUM_CH 40
`define LAST_CH 6'h27

// ----------------------------------------------------------
// reset values
// ----------------------------------------------------------
`define GAIN_RESET 12'hFFF
`define OFFSET_RESET 12'h000
`define DAC_RESET 12'h000
`define CLRCODE_RESET 12'h000
`define MIDSCALE 15'h0800

// ----------------------------------------------------------
// queue and timing
// ----------------------------------------------------------
`define QDEPTH 128
`define QAW 7
`define CLK_NS 20
`define CLR_NS 35000
`define RST_NS 270000
`define SOFT_RST_NS 135000
`define POR_NS 10000
`define CALC_NS 100
`define CLR_CYC ((`CLR_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_CYC ((`RST_NS + `CLK_NS - 1) / `CLK_NS)
`define SOFT_RST_CYC ((`SOFT_RST_NS + `CLK_NS - 1) / `CLK_NS)
`define POR_CYC ((`POR_NS + `CLK_NS - 1) / `CLK_NS)
`define CALC_CYC ((`CALC_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> logic/dac_update_ctrl.v
/*
 update, clear, reset and monitor controller of a 40-channel 12-bit converter, with
 an AXI4-Lite register slave that feeds a command queue.
 assumes one 50 MHz clock, synchronous active-low bus reset and pins that come from
 outside the clock domain.
*/
`timescale 1ns/10ps
`include "dac_ctrl_regs.vh"

module dac_update_ctrl #(
   parameter integer RST_CYCLES = `RST_CYC,
   parameter integer SOFT_RST_CYCLES = `SOFT_RST_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire reset_pin_n,
   input wire async_clear_input_n,
   input wire load_outputs_strobe_n,
   input wire fifo_enable,
   input wire parallel_mode,
   output wire busy_n,
   output reg dac_update_ff,
   output reg [5:0] monitor_channel_ff,
   output reg monitor_active_ff,
   output reg monitor_output_hiz_ff,
   output reg channel_outputs_hiz_ff,
   output reg channel_outputs_grounded_ff
);

   // ----------------------------------------------------------
   // states and loads
   // ----------------------------------------------------------
   localparam [4:0] ST_POR = 5'h01;
   localparam [4:0] ST_IDLE = 5'h02;
   localparam [4:0] ST_CALC = 5'h04;
   localparam [4:0] ST_CLR = 5'h08;
   localparam [4:0] ST_RST = 5'h10;
   localparam integer POR_I = `POR_CYC - 1;
   localparam integer CALC_I = `CALC_CYC - 1;
   localparam integer CLR_I = `CLR_CYC - 1;
   localparam integer RST_I = RST_CYCLES - 1;
   localparam integer SRST_I = SOFT_RST_CYCLES - 1;
   localparam [13:0] POR_LD = POR_I[13:0];
   localparam [13:0] CALC_LD = CALC_I[13:0];
   localparam [13:0] CLR_LD = CLR_I[13:0];
   localparam [13:0] RST_LD = RST_I[13:0];
   localparam [13:0] SRST_LD = SRST_I[13:0];

   // ----------------------------------------------------------
   // pin synchronisers and edges
   // ----------------------------------------------------------
   reg [2:0] rst_sync_ff, clr_sync_ff, load_outputs_strobe_sync_ff;
   reg [1:0] fen_sync_ff, par_sync_ff;
   always @(posedge aclk) begin
      if (!aresetn) begin
         rst_sync_ff <= 3'h7;
         clr_sync_ff <= 3'h7;
         load_outputs_strobe_sync_ff <= 3'h7;
         fen_sync_ff <= 2'h0;
         par_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[1:0], reset_pin_n};
         clr_sync_ff <= {clr_sync_ff[1:0], async_clear_input_n};
         load_outputs_strobe_sync_ff <= {load_outputs_strobe_sync_ff[1:0], load_outputs_strobe_n};
         fen_sync_ff <= {fen_sync_ff[0], fifo_enable};
         par_sync_ff <= {par_sync_ff[0], parallel_mode};
      end
   end
   wire rst_fall = rst_sync_ff[2] & ~rst_sync_ff[1];
   wire clr_fall = clr_sync_ff[2] & ~clr_sync_ff[1];
   wire load_outputs_strobe_low = ~load_outputs_strobe_sync_ff[1];
   wire load_outputs_strobe_fall = load_outputs_strobe_sync_ff[2] & ~load_outputs_strobe_sync_ff[1];

   // ----------------------------------------------------------
   // storage
   // ----------------------------------------------------------
   reg [11:0] input_data_register [0:`NUM_CH-1];
   reg [11:0] gain_ff [0:`NUM_CH-1];
   reg [11:0] offset_ff [0:`NUM_CH-1];
   reg [11:0] corrected_data_register [0:`NUM_CH-1];
   reg [11:0] dac_ff [0:`NUM_CH-1];
   reg [`NUM_CH-1:0] dirty_ff;
   reg [`CMD_W-1:0] queue_ff [0:`QDEPTH-1];
   reg [`QAW-1:0] wptr_ff, rptr_ff;
   reg [`QAW:0] count_ff;
   reg [4:0] state_ff;
   reg [13:0] cnt_ff;
   reg [5:0] calc_ch_ff;
   reg [11:0] ctrl_ff, clrcode_ff;
   reg [5:0] mon_sel_ff, dac_sel_ff;
   reg pdown_ff, fifo_mode_ff, pending_ff;

   // ----------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------
   reg aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
   reg [7:0] awaddr_ff;
   reg [31:0] wdata_ff, rdata_ff;
   reg [1:0] bresp_ff, rresp_ff;
   assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_have_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   wire wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
   wire wr_ok = (awaddr_ff == `OFS_CMD) | (awaddr_ff == `OFS_DAC_SEL);
   wire busy = (state_ff != ST_IDLE) | (count_ff != 8'h00);
   wire host_off = (state_ff == ST_RST) | (state_ff == ST_POR);
   wire q_full = fifo_mode_ff ? (count_ff == 8'h80) : (count_ff != 8'h00);
   wire push = wr_go & (awaddr_ff == `OFS_CMD) & ~host_off & ~q_full;
   wire pop = (state_ff == ST_IDLE) & (count_ff != 8'h00);
   wire [`CMD_W-1:0] cmd = queue_ff[rptr_ff];
   assign busy_n = ~busy;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h00000000;
         rdata_ff <= 32'h00000000;
         bresp_ff <= 2'h0;
         rresp_ff <= 2'h0;
         dac_sel_ff <= 6'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? 2'h0 : 2'h2;
            if (awaddr_ff == `OFS_DAC_SEL) begin
               dac_sel_ff <= wdata_ff[5:0];
            end
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= 2'h0;
            case (s_axi_araddr)
               `OFS_STATUS: rdata_ff <= {16'h0000, count_ff, 2'h0, pending_ff, fifo_mode_ff,
                                         pdown_ff, host_off, state_ff == ST_CLR, busy};
               `OFS_CTRL: rdata_ff <= {20'h00000, mon_sel_ff, 6'h00} | {20'h00000, ctrl_ff};
               `OFS_CLRCODE: rdata_ff <= {20'h00000, clrcode_ff};
               `OFS_DAC_SEL: rdata_ff <= {26'h0000000, dac_sel_ff};
               `OFS_DAC_DATA: rdata_ff <= (dac_sel_ff < `NUM_CH) ? {20'h00000, dac_ff[dac_sel_ff]} :
                                          32'h00000000;
               default: begin
                  rdata_ff <= 32'h00000000;
                  rresp_ff <= 2'h2;
               end
            endcase
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------
   // corrected value of the channel under calculation
   // ----------------------------------------------------------
   wire [24:0] prod = input_data_register[calc_ch_ff] * ({1'b0, gain_ff[calc_ch_ff]} + 13'h0002);
   wire [14:0] sum = {2'h0, prod[24:12]} + {3'h0, offset_ff[calc_ch_ff]};
   wire [14:0] diff = sum - `MIDSCALE;
   wire [11:0] corr = (sum < `MIDSCALE) ? 12'h000 : (diff > 15'h0FFF) ? 12'hFFF : diff[11:0];

   // ----------------------------------------------------------
   // command execution, sequencing and output loading
   // ----------------------------------------------------------
   wire [1:0] c_sel = cmd[`CMD_SEL_HI:`CMD_SEL_LO];
   wire [5:0] c_addr = cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
   wire [11:0] c_data = cmd[11:0];
   wire is_pup = (c_sel == `SEL_SFR) & (c_addr == `SFR_PUP);
   wire exec_ok = ~pdown_ff | is_pup;
   wire apply = ~busy & (pending_ff | load_outputs_strobe_low);
   wire clr_start = clr_fall | (pop & exec_ok & (c_sel == `SEL_SFR) & (c_addr == `SFR_SOFT_CLR));
   wire srst_start = pop & exec_ok & (c_sel == `SEL_SFR) & (c_addr == `SFR_SOFT_RST);
   integer i;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_POR;
         cnt_ff <= POR_LD;
         wptr_ff <= 7'h00;
         rptr_ff <= 7'h00;
         count_ff <= 8'h00;
         calc_ch_ff <= 6'h00;
         ctrl_ff <= `CTRL_RESET;
         clrcode_ff <= `CLRCODE_RESET;
         mon_sel_ff <= `MON_HIZ;
         pdown_ff <= 1'b0;
         fifo_mode_ff <= 1'b0;
         pending_ff <= 1'b0;
         dirty_ff <= {`NUM_CH{1'b0}};
         dac_update_ff <= 1'b0;
         for (i = 0; i < `NUM_CH; i = i + 1) begin
            input_data_register[i] <= 12'h000;
            gain_ff[i] <= `GAIN_RESET;
            offset_ff[i] <= `OFFSET_RESET;
            corrected_data_register[i] <= 12'h000;
            dac_ff[i] <= `DAC_RESET;
         end
      end else begin
         dac_update_ff <= 1'b0;
         if (push) begin
            queue_ff[wptr_ff] <= wdata_ff[`CMD_W-1:0];
            wptr_ff <= wptr_ff + 7'h01;
         end
         if (pop) begin
            rptr_ff <= rptr_ff + 7'h01;
         end
         count_ff <= count_ff + {7'h00, push} - {7'h00, pop};
         // pending load survives a clear; only reset sequences discard it
         if (host_off) begin
            pending_ff <= 1'b0;
         end else if (apply) begin
            pending_ff <= 1'b0;
         end else if (busy && load_outputs_strobe_fall) begin
            pending_ff <= 1'b1;
         end
         if (apply) begin
            dac_update_ff <= 1'b1;
            for (i = 0; i < `NUM_CH; i = i + 1) begin
               if (dirty_ff[i]) begin
                  dac_ff[i] <= corrected_data_register[i];
               end
            end
            dirty_ff <= {`NUM_CH{1'b0}};
         end
         if (pop && exec_ok) begin
            case (c_sel)
               `SEL_INPUT: if (c_addr < `NUM_CH) input_data_register[c_addr] <= c_data;
               `SEL_GAIN: if (c_addr < `NUM_CH) gain_ff[c_addr] <= c_data;
               `SEL_OFFSET: if (c_addr < `NUM_CH) offset_ff[c_addr] <= c_data;
               default: begin
                  case (c_addr)
                     `SFR_CLRCODE: clrcode_ff <= c_data;
                     `SFR_PDOWN: pdown_ff <= 1'b1;
                     `SFR_PUP: pdown_ff <= 1'b0;
                     `SFR_CTRL: ctrl_ff <= c_data;
                     `SFR_MONITOR: mon_sel_ff <= c_data[`CMD_MON_MSB:`CMD_MON_LSB];
                     default: ;
                  endcase
               end
            endcase
         end
         case (state_ff)
            ST_POR: begin
               if (cnt_ff == 14'h0000) begin
                  state_ff <= ST_IDLE;
                  fifo_mode_ff <= fen_sync_ff[1] & par_sync_ff[1];
               end else begin
                  cnt_ff <= cnt_ff - 14'h0001;
               end
            end
            ST_IDLE: begin
               if (rst_fall || srst_start) begin
                  state_ff <= ST_RST;
                  cnt_ff <= rst_fall ? RST_LD : SRST_LD;
               end else if (clr_start) begin
                  state_ff <= ST_CLR;
                  cnt_ff <= CLR_LD;
               end else if (pop && exec_ok && (c_sel != `SEL_SFR || c_addr == `SFR_NOP)) begin
                  state_ff <= ST_CALC;
                  cnt_ff <= CALC_LD;
                  calc_ch_ff <= (c_sel == `SEL_SFR || c_addr >= `NUM_CH) ? 6'h00 : c_addr;
               end
            end
            ST_CALC: begin
               if (rst_fall) begin
                  state_ff <= ST_RST;
                  cnt_ff <= RST_LD;
               end else if (cnt_ff == 14'h0000) begin
                  state_ff <= ST_IDLE;
                  corrected_data_register[calc_ch_ff] <= corr;
                  dirty_ff[calc_ch_ff] <= 1'b1;
               end else begin
                  cnt_ff <= cnt_ff - 14'h0001;
               end
            end
            ST_CLR: begin
               if (rst_fall) begin
                  state_ff <= ST_RST;
                  cnt_ff <= RST_LD;
               end else if (cnt_ff == 14'h0000) begin
                  state_ff <= ST_IDLE;
                  dac_update_ff <= 1'b1;
                  fifo_mode_ff <= fen_sync_ff[1] & par_sync_ff[1];
                  for (i = 0; i < `NUM_CH; i = i + 1) begin
                     dac_ff[i] <= clrcode_ff;
                  end
               end else begin
                  cnt_ff <= cnt_ff - 14'h0001;
               end
            end
            ST_RST: begin
               ctrl_ff <= `CTRL_RESET;
               clrcode_ff <= `CLRCODE_RESET;
               mon_sel_ff <= `MON_HIZ;
               pdown_ff <= 1'b0;
               dirty_ff <= {`NUM_CH{1'b0}};
               wptr_ff <= 7'h00;
               rptr_ff <= 7'h00;
               count_ff <= 8'h00;
               for (i = 0; i < `NUM_CH; i = i + 1) begin
                  input_data_register[i] <= 12'h000;
                  gain_ff[i] <= `GAIN_RESET;
                  offset_ff[i] <= `OFFSET_RESET;
                  corrected_data_register[i] <= 12'h000;
                  dac_ff[i] <= `DAC_RESET;
               end
               if (cnt_ff == 14'h0000) begin
                  state_ff <= ST_IDLE;
                  dac_update_ff <= 1'b1;
                  fifo_mode_ff <= fen_sync_ff[1] & par_sync_ff[1];
               end else begin
                  cnt_ff <= cnt_ff - 14'h0001;
               end
            end
            default: begin
               state_ff <= ST_POR;
               cnt_ff <= POR_LD;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // monitor and analog output state
   // ----------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         monitor_channel_ff <= `LAST_CH;
         monitor_active_ff <= 1'b0;
         monitor_output_hiz_ff <= 1'b0;
         channel_outputs_hiz_ff <= 1'b1;
         channel_outputs_grounded_ff <= 1'b0;
      end else begin
         monitor_active_ff <= ctrl_ff[`CTRL_MON_EN];
         if (!ctrl_ff[`CTRL_MON_EN]) begin
            monitor_channel_ff <= `LAST_CH;
         end else if (mon_sel_ff <= `MON_LAST_CH) begin
            monitor_channel_ff <= mon_sel_ff;
         end else begin
            monitor_channel_ff <= mon_sel_ff;
         end
         monitor_output_hiz_ff <= ctrl_ff[`CTRL_MON_EN] & (mon_sel_ff == `MON_HIZ);
         channel_outputs_hiz_ff <= (state_ff == ST_POR) | (pdown_ff & ctrl_ff[`CTRL_PD_HIZ]);
         channel_outputs_grounded_ff <= pdown_ff & ~ctrl_ff[`CTRL_PD_HIZ];
      end
   end

endmodule

// >>> tb/dac_update_ctrl_properties.sv
/*
 checker of the update controller: busy timing, strobe handling, monitor select.
 assumes binding to dac_update_ctrl and idle pins whenever reset or clear is pulsed.
*/
`timescale 1ns/10ps
`include "dac_ctrl_regs.vh"
module dac_update_ctrl_checker #(
   parameter integer RST_CYCLES = 20,
   parameter integer SOFT_RST_CYCLES = 10
) (
   input wire aclk,
   input wire aresetn,
   input wire reset_pin_n,
   input wire async_clear_input_n,
   input wire load_outputs_strobe_n,
   input wire busy_n,
   input wire dac_update_ff,
   input wire [5:0] monitor_channel_ff,
   input wire monitor_active_ff,
   input wire monitor_output_hiz_ff
);
   int low_run_ff;
   logic clear_arm_ff;
   logic reset_arm_ff;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // length of each busy period and whether a clear or reset pin fall began it
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_run_ff <= 0;
         clear_arm_ff <= 1'b0;
         reset_arm_ff <= 1'b0;
      end else begin
         low_run_ff <= busy_n ? 0 : low_run_ff + 1;
         if ($rose(busy_n)) begin
            clear_arm_ff <= 1'b0;
            reset_arm_ff <= 1'b0;
         end else begin
            if ($fell(async_clear_input_n) && busy_n) clear_arm_ff <= 1'b1;
            if ($fell(reset_pin_n) && busy_n) reset_arm_ff <= 1'b1;
         end
      end
   end
   a_hiz_needs_63: assert property (monitor_output_hiz_ff |-> monitor_active_ff && monitor_channel_ff == 6'h3F)
      else $error("monitor hiz without select 63");
   a_idle_last_ch: assert property (!monitor_active_ff |-> monitor_channel_ff == 6'h27)
      else $error("monitor off but last channel not routed");
   a_reset_holds_busy: assert property ($fell(reset_pin_n) && busy_n |-> ##6 (!busy_n) [*8])
      else $error("busy not held low by reset");
   a_reset_length: assert property ($rose(busy_n) && reset_arm_ff |-> low_run_ff >= RST_CYCLES - 2 && low_run_ff <= RST_CYCLES + 2)
      else $error("reset busy period has wrong length");
   a_clear_length: assert property ($rose(busy_n) && clear_arm_ff |-> low_run_ff >= 1748 && low_run_ff <= 1752)
      else $error("clear busy period has wrong length");
   a_reset_quiet: assert property (reset_arm_ff && low_run_ff > 2 && low_run_ff < RST_CYCLES - 3 |-> !dac_update_ff)
      else $error("outputs updated during reset");
   a_held_strobe: assert property ($rose(busy_n) && !load_outputs_strobe_n |-> ##[1:4] dac_update_ff)
      else $error("held strobe gave no update after busy");
   a_fall_applies: assert property ($fell(load_outputs_strobe_n) && busy_n |-> ##[1:6] dac_update_ff)
      else $error("strobe while idle gave no update");
endmodule
bind dac_update_ctrl dac_update_ctrl_checker #(.RST_CYCLES(RST_CYCLES), .SOFT_RST_CYCLES(SOFT_RST_CYCLES))
   dac_update_ctrl_checker_i (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
   .async_clear_input_n(async_clear_input_n), .load_outputs_strobe_n(load_outputs_strobe_n), .busy_n(busy_n),
   .dac_update_ff(dac_update_ff), .monitor_channel_ff(monitor_channel_ff), .monitor_active_ff(monitor_active_ff),
   .monitor_output_hiz_ff(monitor_output_hiz_ff));

// >>> tb/host_pins_model.sv
/*
 host side of the converter pins: reset, clear, load strobe and interface mode.
 assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/10ps
module host_pins_model (
   input wire aclk,
   output logic reset_pin_n,
   output logic async_clear_input_n,
   output logic load_outputs_strobe_n,
   output logic fifo_enable,
   output logic parallel_mode
);
   initial begin
      reset_pin_n = 1'b1;
      async_clear_input_n = 1'b1;
      load_outputs_strobe_n = 1'b1;
      parallel_mode = 1'b0;
      fifo_enable = 1'b0;
   end
   // queue enable only ever rides on the parallel interface
   task set_parallel(input logic on);
      parallel_mode <= on;
      fifo_enable <= on;
   endtask
   // pin 0 reset, 1 clear, 2 strobe: low for some clocks
   task pulse(input int pin, input int cycles);
      if (pin == 0) reset_pin_n <= 1'b0;
      else if (pin == 1) async_clear_input_n <= 1'b0;
      else load_outputs_strobe_n <= 1'b0;
      repeat (cycles) @(posedge aclk);
      reset_pin_n <= 1'b1;
      async_clear_input_n <= 1'b1;
      load_outputs_strobe_n <= 1'b1;
   endtask
   task hold_strobe(input logic level);
      load_outputs_strobe_n <= level;
   endtask
endmodule

// >>> tb/dac_update_ctrl_bench.sv
/*
 bench of the update controller: bus master, table of monitor cases, pin scenarios.
 assumes the checker binds itself and the pin model drives the device pins.
*/
`timescale 1ns/10ps
`include "dac_ctrl_regs.vh"
module dac_update_ctrl_bench;
   localparam int EXP_FULL = (4095 * (`GAIN_RESET + 2)) / 4096 + `OFFSET_RESET - 2048;
   typedef struct packed {logic [11:0] ctrl; logic [5:0] sel; logic [5:0] ch; logic hiz; logic act;} row_t;
   row_t rows [5] = '{'{12'h080, 6'd0, 6'd0, 1'b0, 1'b1}, '{12'h080, 6'd17, 6'd17, 1'b0, 1'b1},
      '{12'h080, 6'd38, 6'd38, 1'b0, 1'b1}, '{12'h080, 6'd63, 6'd63, 1'b1, 1'b1}, '{12'h000, 6'd5, 6'd39, 1'b0, 1'b0}};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [1:0] rr;
   logic [3:0] wstrb;
   wire awready, wready, bvalid, arready, rvalid, reset_n, clear_n, strobe_n, fifo_en, par;
   wire busy_n, upd, mon_act, mon_hiz, out_hiz, out_gnd;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [5:0] mon_ch;
   int mismatches, checks_done;
   dac_update_ctrl #(.RST_CYCLES(20), .SOFT_RST_CYCLES(10)) dac_update_ctrl_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .reset_pin_n(reset_n), .async_clear_input_n(clear_n),
      .load_outputs_strobe_n(strobe_n), .fifo_enable(fifo_en), .parallel_mode(par), .busy_n(busy_n),
      .dac_update_ff(upd), .monitor_channel_ff(mon_ch), .monitor_active_ff(mon_act),
      .monitor_output_hiz_ff(mon_hiz), .channel_outputs_hiz_ff(out_hiz), .channel_outputs_grounded_ff(out_gnd));
   host_pins_model host_pins_model_i (.aclk(aclk), .reset_pin_n(reset_n), .async_clear_input_n(clear_n),
      .load_outputs_strobe_n(strobe_n), .fifo_enable(fifo_en), .parallel_mode(par));
   // ----------------------------------------
   // bus, compare and closing tasks
   // ----------------------------------------
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task hang;
      mismatches++;
      $display("ERROR wait expected done seen timeout");
      report_and_stop;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) hang;
      chk("write response", 2'b00, bresp);
      @(posedge aclk);
   endtask
   task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 50) hang;
      @(posedge aclk);
   endtask
   task wait_idle;
      int n;
      for (n = 0; n < 30000; n++) begin
         @(posedge aclk);
         if (busy_n === 1'b1) break;
      end
      if (n == 30000) hang;
      @(posedge aclk);
   endtask
   task run(input logic [1:0] s, input logic [5:0] a, input logic [11:0] d);
      axi_write(`OFS_CMD, {12'h000, s, a, d});
      wait_idle;
   endtask
   task dac_rd(input logic [5:0] ch);
      axi_write(`OFS_DAC_SEL, {26'h0, ch});
      axi_read(`OFS_DAC_DATA, rd, rr);
   endtask
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      mismatches = 0;
      checks_done = 0;
      repeat (6) @(posedge aclk);
      chk("busy in reset", 0, busy_n);
      chk("outputs hiz in reset", 1, out_hiz);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("busy at power-on", 0, busy_n);
      wait_idle;
      chk("outputs after power-on", 0, out_hiz);
      foreach (rows[i]) begin
         run(`SEL_SFR, `SFR_CTRL, rows[i].ctrl);
         run(`SEL_SFR, `SFR_MONITOR, {rows[i].sel, 6'h00});
         chk("monitor channel", rows[i].ch, mon_ch);
         chk("monitor hiz", rows[i].hiz, mon_hiz);
         chk("monitor active", rows[i].act, mon_act);
      end
      run(`SEL_SFR, `SFR_CLRCODE, 12'h123);
      host_pins_model_i.pulse(1, 4);
      wait_idle;
      dac_rd(6'd4);
      chk("dac after clear", 32'h123, rd);
      axi_write(`OFS_CMD, {12'h000, `SEL_INPUT, 6'd3, 12'hFFF});
      host_pins_model_i.pulse(2, 2);
      wait_idle;
      dac_rd(6'd3);
      chk("dac deferred load", EXP_FULL, rd);
      dac_rd(6'd4);
      chk("dac unwritten channel", 32'h123, rd);
      host_pins_model_i.hold_strobe(1'b0);
      repeat (4) @(posedge aclk);
      run(`SEL_INPUT, 6'd5, 12'hFFF);
      dac_rd(6'd5);
      chk("dac strobe held", EXP_FULL, rd);
      host_pins_model_i.hold_strobe(1'b1);
      run(`SEL_INPUT, 6'd6, 12'hFFF);
      dac_rd(6'd6);
      chk("dac without strobe", 32'h123, rd);
      host_pins_model_i.set_parallel(1'b1);
      @(posedge aclk);
      host_pins_model_i.pulse(0, 4);
      host_pins_model_i.pulse(2, 3);
      wait_idle;
      dac_rd(6'd3);
      chk("dac after reset", 0, rd);
      axi_read(`OFS_STATUS, rd, rr);
      chk("queue mode", 1, rd[4]);
      chk("pending load", 0, rd[5]);
      axi_write(`OFS_CMD, {12'h000, `SEL_SFR, `SFR_SOFT_CLR, 12'h000});
      for (int i = 0; i < `QDEPTH + 2; i++) axi_write(`OFS_CMD, {12'h000, `SEL_INPUT, 6'd8, 12'h100});
      axi_read(`OFS_STATUS, rd, rr);
      chk("queue count", `QDEPTH, rd[15:8]);
      wait_idle;
      axi_read(8'h40, rd, rr);
      chk("unmapped response", 2'b10, rr);
      run(`SEL_SFR, `SFR_PDOWN, 12'h000);
      chk("outputs in power-down", 1, out_hiz);
      chk("outputs grounded in power-down", 0, out_gnd);
      run(`SEL_INPUT, 6'd9, 12'hFFF);
      run(`SEL_SFR, `SFR_PUP, 12'h000);
      host_pins_model_i.pulse(2, 3);
      repeat (8) @(posedge aclk);
      dac_rd(6'd9);
      chk("dac write in power-down", 0, rd);
      report_and_stop;
   end
endmodule
